// File: energy_mode_pkg.sv
// Constants and carrier types shared by the energy-mode power-domain control.
// Assumes a single 200 MHz system clock and a synchronous reset.
package energy_mode_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int DOMAIN_RAMP_NS  = 50;  // Least time for a domain to settle
  localparam int ISO_SETUP_NS    = 20;  // Least isolation time before cut
  localparam int RAMP_CYCLES     =
    (DOMAIN_RAMP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ISO_CYCLES      =
    (ISO_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W           = 8;
  // Worst switch turnaround: finish isolation, idle one cycle, full ramp
  localparam int SETTLE_CYCLES   = ISO_CYCLES + RAMP_CYCLES + 2;

  // ----------------------------------------------------------------------
  // Domains and levels
  // ----------------------------------------------------------------------
  localparam int NUM_DOMAINS     = 6;
  localparam int DOM_BASE        = 0;
  localparam int DOM_AUX_B       = 1;
  localparam int DOM_AUX_C       = 2;
  localparam int DOM_AUX_D       = 3;
  localparam int DOM_SHARED      = 4;
  localparam int DOM_ACTIVE      = 5;

  typedef enum logic [4:0] {
    RUN_MODE        = 5'h01,
    SLEEP_MODE      = 5'h02,
    DEEP_SLEEP_MODE = 5'h04,
    STOP_MODE       = 5'h08,
    SHUTOFF_MODE    = 5'h10
  } energy_mode_type;

  typedef enum logic [1:0] {
    LOWEST_VOLTAGE_LEVEL       = 2'h0,
    INTERMEDIATE_VOLTAGE_LEVEL = 2'h1,
    TOP_VOLTAGE_LEVEL          = 2'h2
  } voltage_level_type;

  localparam voltage_level_type RUN_LEVEL_RESET = TOP_VOLTAGE_LEVEL;
  localparam voltage_level_type LOW_LEVEL_RESET = LOWEST_VOLTAGE_LEVEL;
  localparam energy_mode_type   MODE_RESET      = RUN_MODE;

  // Per-domain switch outputs
  typedef struct packed {
    logic [NUM_DOMAINS-1:0] pwr_en;   // Domain supply switch closed
    logic [NUM_DOMAINS-1:0] iso;      // Isolation and reset held
  } domain_ctrl_type;

  // Peripheral enables grouped by the auxiliary domain they sit on
  typedef struct packed {
    logic aux_b;
    logic aux_c;
    logic aux_d;
    logic shared_aux;
  } aux_enable_type;

endpackage

// File: domain_switch.sv
// One power-domain switch with ordered isolation around supply changes.
// Assumes want_on comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module domain_switch (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic want_on,
  output logic      pwr_en,
  output logic      iso
);

  typedef enum logic [3:0] {
    SW_OFF  = 4'h1,
    SW_RAMP = 4'h2,
    SW_ON   = 4'h4,
    SW_ISO  = 4'h8
  } sw_state_type;

  sw_state_type                        state_q;
  sw_state_type                        state_d;
  logic [energy_mode_pkg::CNT_W-1:0]   cnt_q;
  logic [energy_mode_pkg::CNT_W-1:0]   cnt_d;
  wire logic                           ramp_done;
  wire logic                           iso_done;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  assign ramp_done = cnt_q ==
    energy_mode_pkg::CNT_W'(energy_mode_pkg::RAMP_CYCLES - 1);
  assign iso_done = cnt_q ==
    energy_mode_pkg::CNT_W'(energy_mode_pkg::ISO_CYCLES - 1);

  // Next state; a ramp always completes so the rail never chatters
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + energy_mode_pkg::CNT_W'(1);
    case (state_q)
      SW_OFF: begin
        cnt_d = '0;
        if (want_on) begin
          state_d = SW_RAMP;
        end
      end
      SW_RAMP: begin
        if (ramp_done) begin
          cnt_d   = '0;
          state_d = want_on ? SW_ON : SW_OFF;  // [R17]
        end
      end
      SW_ON: begin
        cnt_d = '0;
        if (!want_on) begin
          state_d = SW_ISO;  // [R17]
        end
      end
      SW_ISO: begin
        if (iso_done) begin
          cnt_d   = '0;
          state_d = SW_OFF;
        end
      end
      default: begin
        cnt_d   = '0;
        state_d = SW_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= SW_OFF;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Outputs straight from the one-hot state flops
  assign pwr_en = state_q[1] | state_q[2] | state_q[3];
  assign iso    = !state_q[2];  // [R17]

  // Isolation released only with the supply up
  AST_ISO_NEEDS_PWR: assert property (@(posedge clk) disable iff (sys_rst)
    !iso |-> pwr_en) else $error("isolation released without power");  // [R17]

  // Supply cut only after isolation held for the setup time
  AST_ISO_BEFORE_CUT: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pwr_en) |-> $past(iso) && $past(iso, 4))
    else $error("supply cut without isolation setup");  // [R17]

endmodule
`default_nettype wire

// File: energy_mode_power_domain_ctrl.sv
// Energy-mode power-domain controller: domain switches, regulator level,
// RAM block power and the supply-low interrupt.
// Assumes mode request and enables come from logic on clk; supply_low is
// an asynchronous analog comparator level.
//
// Summary of operation
// R01 - Always-on domain stays powered in every mode, shutoff included.
// R02 - Shutoff mode powers down every low-power domain.
// R03 - Base retention domain powered in run, sleep, deep-sleep and stop.
// R04 - Aux domain powered in deep-sleep and stop while a peripheral uses it.
// R05 - Aux domain powered down when none of its peripherals is enabled.
// R06 - Shared aux domain powered whenever aux b, c or d is in use; the code keeps it off in shutoff.
// R07 - Active domain always powered in run and sleep.
// R08 - Active domain always off in deep-sleep, stop and shutoff.
// R09 - Peripherals not on always-on or low-power domains use the active one.
// R10 - Two voltage selections: run/sleep and deep-sleep/stop.
// R11 - Run/sleep selection resets to the top voltage level.
// R12 - Software picks intermediate level only at core clock up to 40 MHz.
// R13 - Lowest level is selectable for deep-sleep and stop.
// R14 - Regulator target follows the mode's selection on every transition.
// R15 - Software can switch off power to unused RAM blocks.
// R16 - Low supply raises a maskable interrupt for buck bypass.
// R17 - Domain powers up before isolation release; isolates before cut.
`timescale 1ns/1ps
`default_nettype none
module energy_mode_power_domain_ctrl #(
  parameter int RAM_BLOCKS = 8
) (
  input  wire logic                               clk,
  input  wire logic                               sys_rst,
  input  wire energy_mode_pkg::energy_mode_type   mode_req,
  input  wire energy_mode_pkg::aux_enable_type    aux_en,
  input  wire logic                               active_periph_en,
  input  wire energy_mode_pkg::voltage_level_type run_level_sel,
  input  wire logic                               run_level_wr,
  input  wire energy_mode_pkg::voltage_level_type low_level_sel,
  input  wire logic                               low_level_wr,
  input  wire logic [RAM_BLOCKS-1:0]              ram_unused,
  input  wire logic                               supply_low,
  input  wire logic                               supply_irq_en,
  input  wire logic                               supply_irq_clr,
  output energy_mode_pkg::energy_mode_type        mode,
  output logic                                    always_on_domain,
  output energy_mode_pkg::domain_ctrl_type        domains,
  output logic                                    active_periph_iso,
  output energy_mode_pkg::voltage_level_type      regulator_target,
  output energy_mode_pkg::voltage_level_type      run_level,
  output energy_mode_pkg::voltage_level_type      low_level,
  output logic [RAM_BLOCKS-1:0]                   ram_pwr_en,
  output logic                                    supply_low_flag,
  output logic                                    supply_irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  energy_mode_pkg::energy_mode_type   mode_q;
  energy_mode_pkg::voltage_level_type run_level_q;
  energy_mode_pkg::voltage_level_type low_level_q;
  energy_mode_pkg::voltage_level_type target_q;
  energy_mode_pkg::voltage_level_type target_d;
  logic [RAM_BLOCKS-1:0]              ram_pwr_q;
  logic                               low_meta_q;
  logic                               low_sync_q;
  logic                               low_prev_q;
  logic                               flag_q;
  wire logic [energy_mode_pkg::NUM_DOMAINS-1:0] want_on;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire logic is_awake   = (mode_q == energy_mode_pkg::RUN_MODE) ||
                          (mode_q == energy_mode_pkg::SLEEP_MODE);
  wire logic is_low     = (mode_q == energy_mode_pkg::DEEP_SLEEP_MODE) ||
                          (mode_q == energy_mode_pkg::STOP_MODE);
  wire logic is_shutoff = (mode_q == energy_mode_pkg::SHUTOFF_MODE);
  wire logic any_bcd    = aux_en.aux_b | aux_en.aux_c | aux_en.aux_d;
  wire logic low_rise   = low_sync_q & !low_prev_q;

  // Unknown or multi-hot requests are ignored; the mode stays put
  wire logic req_legal  = $onehot(mode_req);

  // Mode register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= energy_mode_pkg::MODE_RESET;
    end else if (req_legal) begin
      mode_q <= mode_req;
    end
  end

  // ----------------------------------------------------------------------
  // Domain demand
  // ----------------------------------------------------------------------
  assign always_on_domain = 1'b1;  // [R01]

  // Auxiliary domains follow their peripheral enables in any mode but shutoff
  assign want_on[energy_mode_pkg::DOM_BASE]   = !is_shutoff;  // [R02] [R03]
  assign want_on[energy_mode_pkg::DOM_AUX_B]  =
    !is_shutoff & aux_en.aux_b;  // [R04] [R05]
  assign want_on[energy_mode_pkg::DOM_AUX_C]  =
    !is_shutoff & aux_en.aux_c;  // [R04] [R05]
  assign want_on[energy_mode_pkg::DOM_AUX_D]  =
    !is_shutoff & aux_en.aux_d;  // [R04] [R05]
  assign want_on[energy_mode_pkg::DOM_SHARED] =
    !is_shutoff & (aux_en.shared_aux | any_bcd);  // [R06]
  // Every unlisted peripheral lives here, so it tracks the awake modes only
  assign want_on[energy_mode_pkg::DOM_ACTIVE] = is_awake;  // [R07] [R08] [R09]

  // One sequenced switch per domain
  genvar g;
  generate
    for (g = 0; g < energy_mode_pkg::NUM_DOMAINS; g++) begin : g_dom
      domain_switch u_switch (
        .clk     (clk),
        .sys_rst (sys_rst),
        .want_on (want_on[g]),
        .pwr_en  (domains.pwr_en[g]),
        .iso     (domains.iso[g])
      );
    end
  endgenerate

  // Active peripherals stay isolated when disabled or unpowered
  assign active_periph_iso =
    domains.iso[energy_mode_pkg::DOM_ACTIVE] | !active_periph_en;  // [R09]

  // ----------------------------------------------------------------------
  // Voltage scaling
  // ----------------------------------------------------------------------
  // Lowest level cannot hold a running core, so run writes refuse it
  wire logic run_wr_ok = run_level_wr &&
    (run_level_sel != energy_mode_pkg::LOWEST_VOLTAGE_LEVEL) &&
    (run_level_sel <= energy_mode_pkg::TOP_VOLTAGE_LEVEL);  // [R12]
  wire logic low_wr_ok = low_level_wr &&
    (low_level_sel <= energy_mode_pkg::TOP_VOLTAGE_LEVEL);  // [R13]

  // Selection registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_level_q <= energy_mode_pkg::RUN_LEVEL_RESET;  // [R11]
      low_level_q <= energy_mode_pkg::LOW_LEVEL_RESET;
    end else begin
      if (run_wr_ok) begin
        run_level_q <= run_level_sel;  // [R10]
      end
      if (low_wr_ok) begin
        low_level_q <= low_level_sel;  // [R10] [R13]
      end
    end
  end

  // Target follows the mode with no software step
  assign target_d = is_awake ? run_level_q : low_level_q;  // [R14]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      target_q <= energy_mode_pkg::RUN_LEVEL_RESET;
    end else begin
      target_q <= target_d;
    end
  end

  // ----------------------------------------------------------------------
  // RAM block power
  // ----------------------------------------------------------------------
  // Retention RAM lives on the base domain, so shutoff loses it anyway
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ram_pwr_q <= '1;
    end else begin
      ram_pwr_q <= is_shutoff ? '0 : ~ram_unused;  // [R15]
    end
  end

  // ----------------------------------------------------------------------
  // Supply monitor
  // ----------------------------------------------------------------------
  // Two-stage synchroniser, then edge detect on the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_meta_q <= 1'b0;
      low_sync_q <= 1'b0;
      low_prev_q <= 1'b0;
      flag_q     <= 1'b0;
    end else begin
      low_meta_q <= supply_low;
      low_sync_q <= low_meta_q;
      low_prev_q <= low_sync_q;
      flag_q     <= low_rise | (flag_q & !supply_irq_clr);  // [R16]
    end
  end

  assign mode             = mode_q;
  assign regulator_target = target_q;
  assign run_level        = run_level_q;
  assign low_level        = low_level_q;
  assign ram_pwr_en       = ram_pwr_q;
  assign supply_low_flag  = flag_q;
  assign supply_irq       = flag_q & supply_irq_en;  // [R16]

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  localparam logic [energy_mode_pkg::CNT_W-1:0] HOLD_LAST =
    energy_mode_pkg::CNT_W'(energy_mode_pkg::SETTLE_CYCLES - 1);

  // Watched conditions; counters replace long repetitions in the checks
  wire logic [6:0] hold_cond = {
    is_shutoff,              // 6
    !is_shutoff,             // 5
    is_low && aux_en.aux_b,  // 4
    !aux_en.aux_c,           // 3
    any_bcd && !is_shutoff,  // 2
    is_awake,                // 1
    !is_awake                // 0
  };
  logic [6:0][energy_mode_pkg::CNT_W-1:0] hold_q;
  wire logic [6:0]                        held;

  // Held once a condition has stood for the worst switch turnaround
  genvar h;
  generate
    for (h = 0; h < 7; h++) begin : g_hold
      assign held[h] = hold_cond[h] && (hold_q[h] >= HOLD_LAST);
    end
  endgenerate

  // Saturating counts, cleared whenever the condition drops
  always_ff @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (sys_rst || !hold_cond[i]) begin
        hold_q[i] <= '0;
      end else if (!held[i]) begin
        hold_q[i] <= hold_q[i] + energy_mode_pkg::CNT_W'(1);
      end
    end
  end

  AST_ALWAYS_ON: assert property (@(posedge clk) disable iff (sys_rst)
    always_on_domain) else $error("always-on domain dropped");  // [R01]

  AST_SHUTOFF_ALL_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    held[6] |-> domains.pwr_en == '0)
    else $error("low-power domain alive in shutoff");  // [R02]

  AST_BASE_ON: assert property (@(posedge clk) disable iff (sys_rst)
    held[5] |-> domains.pwr_en[energy_mode_pkg::DOM_BASE] &&
    !domains.iso[energy_mode_pkg::DOM_BASE])
    else $error("base retention domain not up");  // [R03]

  AST_AUX_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
    held[4] |->
    domains.pwr_en[energy_mode_pkg::DOM_AUX_B])
    else $error("aux b off while in use");  // [R04]

  AST_AUX_DROPS: assert property (@(posedge clk) disable iff (sys_rst)
    held[3] |-> !domains.pwr_en[energy_mode_pkg::DOM_AUX_C])
    else $error("aux c on while unused");  // [R05]

  AST_SHARED_WITH_BCD: assert property (@(posedge clk) disable iff (sys_rst)
    held[2] |->
    domains.pwr_en[energy_mode_pkg::DOM_SHARED])
    else $error("shared aux off while b, c or d used");  // [R06]

  AST_ACTIVE_AWAKE: assert property (@(posedge clk) disable iff (sys_rst)
    held[1] |-> domains.pwr_en[energy_mode_pkg::DOM_ACTIVE])
    else $error("active domain off while awake");  // [R07]

  AST_ACTIVE_ASLEEP: assert property (@(posedge clk) disable iff (sys_rst)
    held[0] |-> !domains.pwr_en[energy_mode_pkg::DOM_ACTIVE])
    else $error("active domain on while asleep");  // [R08]

  AST_TARGET_SWITCH: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(mode_q) |=> regulator_target ==
    ($past(is_awake) ? $past(run_level_q) : $past(low_level_q)))
    else $error("regulator target did not follow mode");  // [R14]

  AST_RUN_NOT_LOWEST: assert property (@(posedge clk) disable iff (sys_rst)
    run_level_q != energy_mode_pkg::LOWEST_VOLTAGE_LEVEL)
    else $error("run level at lowest");  // [R12]

  AST_SUPPLY_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(low_sync_q) && supply_irq_en |=> supply_irq)
    else $error("low supply did not interrupt");  // [R16]

  AST_RAM_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    ram_unused[0] |=> !ram_pwr_en[0])
    else $error("unused RAM block still powered");  // [R15]

endmodule
`default_nettype wire

// File: mode_requester.sv
// Model of the processor and peripherals that drive the power controller.
// Assumes the controller samples on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module mode_requester #(
  parameter int CORE_MHZ = 40
) (
  input  wire logic                          clk,
  output energy_mode_pkg::energy_mode_type   mode_req,
  output energy_mode_pkg::aux_enable_type    aux_en,
  output logic                               active_periph_en,
  output energy_mode_pkg::voltage_level_type run_level_sel,
  output logic                               run_level_wr,
  output energy_mode_pkg::voltage_level_type low_level_sel,
  output logic                               low_level_wr,
  output logic [7:0]                         ram_unused,
  output logic                               supply_low,
  output logic                               supply_irq_en,
  output logic                               supply_irq_clr
);
  // ----------------------------------------------------------------------
  // Idle state at time zero
  // ----------------------------------------------------------------------
  initial begin
    mode_req         = energy_mode_pkg::RUN_MODE;
    aux_en           = '0;
    active_periph_en = 1'b0;
    run_level_sel    = energy_mode_pkg::TOP_VOLTAGE_LEVEL;
    run_level_wr     = 1'b0;
    low_level_sel    = energy_mode_pkg::LOWEST_VOLTAGE_LEVEL;
    low_level_wr     = 1'b0;
    ram_unused       = 8'h00;
    supply_low       = 1'b0;
    supply_irq_en    = 1'b0;
    supply_irq_clr   = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Requests, all launched on the falling edge
  // ----------------------------------------------------------------------
  task automatic request_mode(input energy_mode_pkg::energy_mode_type m);
    @(negedge clk);
    mode_req = m;
  endtask

  task automatic set_enables(input logic [3:0] aux, input logic act);
    @(negedge clk);
    aux_en           = aux;
    active_periph_en = act;
  endtask

  // Intermediate level is withheld when the core runs too fast
  task automatic write_run(input energy_mode_pkg::voltage_level_type v);
    if (v == energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL &&
        CORE_MHZ > 40) begin
      return;
    end
    @(negedge clk);
    run_level_sel = v;
    run_level_wr  = 1'b1;
    @(negedge clk);
    run_level_wr  = 1'b0;
  endtask

  task automatic write_low(input energy_mode_pkg::voltage_level_type v);
    @(negedge clk);
    low_level_sel = v;
    low_level_wr  = 1'b1;
    @(negedge clk);
    low_level_wr  = 1'b0;
  endtask

  task automatic set_misc(input logic [7:0] ram, input logic low,
                          input logic irq_en);
    @(negedge clk);
    ram_unused    = ram;
    supply_low    = low;
    supply_irq_en = irq_en;
  endtask

  task automatic pulse_clear();
    @(negedge clk);
    supply_irq_clr = 1'b1;
    @(negedge clk);
    supply_irq_clr = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the energy-mode power-domain controller.
// Assumes mode_requester drives every controller input except clk and sys_rst, which the bench drives.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin tests_run++; \
  if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module tb;
  // ----------------------------------------------------------------------
  // Signals, clock and instances
  // ----------------------------------------------------------------------
  logic                                 clk;
  logic                                 sys_rst;
  energy_mode_pkg::energy_mode_type     mode_req, mode;
  energy_mode_pkg::aux_enable_type      aux_en;
  energy_mode_pkg::voltage_level_type   run_sel, low_sel;
  energy_mode_pkg::voltage_level_type   target, run_level, low_level;
  energy_mode_pkg::domain_ctrl_type     domains;
  logic                                 act_en, run_wr, low_wr, aon, act_iso;
  logic [7:0]                           ram_unused, ram_pwr;
  logic                                 s_low, s_en, s_clr, s_flag, s_irq;
  logic [5:0]                           prev_pwr, prev_iso;
  int                                   mismatches, tests_run, cycles;
  localparam logic [5:0] M_BASE = 6'h01 << energy_mode_pkg::DOM_BASE;
  localparam logic [5:0] M_SHR  = 6'h01 << energy_mode_pkg::DOM_SHARED;
  localparam logic [5:0] M_ACT  = 6'h01 << energy_mode_pkg::DOM_ACTIVE;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  mode_requester far (.clk(clk), .mode_req(mode_req), .aux_en(aux_en),
    .active_periph_en(act_en), .run_level_sel(run_sel), .run_level_wr(run_wr),
    .low_level_sel(low_sel), .low_level_wr(low_wr), .ram_unused(ram_unused),
    .supply_low(s_low), .supply_irq_en(s_en), .supply_irq_clr(s_clr));

  energy_mode_power_domain_ctrl dut (.clk(clk), .sys_rst(sys_rst),
    .mode_req(mode_req), .aux_en(aux_en), .active_periph_en(act_en),
    .run_level_sel(run_sel), .run_level_wr(run_wr), .low_level_sel(low_sel),
    .low_level_wr(low_wr), .ram_unused(ram_unused), .supply_low(s_low),
    .supply_irq_en(s_en), .supply_irq_clr(s_clr), .mode(mode),
    .always_on_domain(aon), .domains(domains), .active_periph_iso(act_iso),
    .regulator_target(target), .run_level(run_level),
    .low_level(low_level), .ram_pwr_en(ram_pwr), .supply_low_flag(s_flag),
    .supply_irq(s_irq));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Settled domain state: powered exactly where expected, isolated elsewhere
  task automatic check_dom(input string what, input logic [5:0] exp);
    `CHECK(what, exp, domains.pwr_en)
    `CHECK(what, ~exp, domains.iso)
  endtask

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, mismatches);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watch every switch: isolation lifts only on a powered domain, power is
  // cut only on an isolated one
  always @(negedge clk) begin
    if (!sys_rst) begin
      for (int i = 0; i < 6; i++) begin
        if (domains.iso[i] === 1'b0 && prev_iso[i] !== 1'b0) begin
          `CHECK("iso release after power", 1'b1, prev_pwr[i])
        end
        if (domains.pwr_en[i] === 1'b0 && prev_pwr[i] !== 1'b0) begin
          `CHECK("cut after isolation", 1'b1, prev_iso[i])
        end
      end
    end
    prev_pwr = domains.pwr_en;
    prev_iso = domains.iso;
  end

  // Hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    settle(3);
    `CHECK("mode", energy_mode_pkg::RUN_MODE, mode)
    `CHECK("target", energy_mode_pkg::TOP_VOLTAGE_LEVEL, target)
    `CHECK("run level", energy_mode_pkg::TOP_VOLTAGE_LEVEL, run_level)
    `CHECK("low level", energy_mode_pkg::LOWEST_VOLTAGE_LEVEL, low_level)
    check_dom("reset domains", 6'h00);
    `CHECK("reset irq", 1'b0, s_irq)
    sys_rst = 1'b0;
    settle(16);
    check_dom("run domains", M_BASE | M_ACT);
    `CHECK("always on", 1'b1, aon)
    end_test("reset");

    // Active peripherals follow the active domain and their own enable
    `CHECK("periph iso off", 1'b1, act_iso)
    far.set_enables(4'h0, 1'b1);
    settle(2);
    `CHECK("periph iso on", 1'b0, act_iso)
    far.request_mode(energy_mode_pkg::energy_mode_type'(5'h03));
    settle(4);
    `CHECK("odd request ignored", energy_mode_pkg::RUN_MODE, mode)
    end_test("active");

    // Level selections and automatic switch on mode change
    far.write_run(energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL);
    settle(2);
    `CHECK("run level mid",
      energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL, target)
    far.write_run(energy_mode_pkg::LOWEST_VOLTAGE_LEVEL);
    settle(2);
    `CHECK("run lowest refused",
      energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL, run_level)
    far.request_mode(energy_mode_pkg::DEEP_SLEEP_MODE);
    settle(4);
    `CHECK("deep mode", energy_mode_pkg::DEEP_SLEEP_MODE, mode)
    `CHECK("deep target",
      energy_mode_pkg::LOWEST_VOLTAGE_LEVEL, target)
    `CHECK("active isolated",
      1'b1, domains.iso[energy_mode_pkg::DOM_ACTIVE])
    `CHECK("periph iso deep", 1'b1, act_iso)
    settle(12);
    check_dom("deep domains", M_BASE);
    end_test("deep");

    // Each auxiliary domain brings the shared one with it
    for (int i = 0; i < 3; i++) begin
      far.set_enables(4'h8 >> i, 1'b1);
      settle(16);
      check_dom("aux on", M_BASE | M_SHR | (6'h02 << i));
      far.set_enables(4'h0, 1'b1);
      settle(16);
      check_dom("aux off", M_BASE);
    end
    far.set_enables(4'h1, 1'b1);
    settle(16);
    check_dom("shared alone", M_BASE | M_SHR);
    end_test("aux");

    // Stop mode uses the second selection
    far.write_low(energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL);
    far.request_mode(energy_mode_pkg::STOP_MODE);
    settle(4);
    `CHECK("stop target",
      energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL, target)
    far.write_low(energy_mode_pkg::voltage_level_type'(2'h3));
    settle(2);
    `CHECK("low level kept",
      energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL, low_level)
    settle(12);
    check_dom("stop domains", M_BASE | M_SHR);
    end_test("stop");

    // Shutoff drops every domain group member but not always-on
    far.request_mode(energy_mode_pkg::SHUTOFF_MODE);
    settle(16);
    check_dom("shutoff domains", 6'h00);
    `CHECK("always on shutoff", 1'b1, aon)
    `CHECK("ram shutoff", 8'h00, ram_pwr)
    far.set_enables(4'h0, 1'b1);
    far.request_mode(energy_mode_pkg::SLEEP_MODE);
    settle(16);
    check_dom("sleep domains", M_BASE | M_ACT);
    `CHECK("sleep target",
      energy_mode_pkg::INTERMEDIATE_VOLTAGE_LEVEL, target)
    far.write_run(energy_mode_pkg::TOP_VOLTAGE_LEVEL);
    settle(2);
    `CHECK("sleep top", energy_mode_pkg::TOP_VOLTAGE_LEVEL, target)
    end_test("shutoff");

    // RAM block power and the low-supply event
    far.set_misc(8'ha5, 1'b1, 1'b0);
    settle(5);
    `CHECK("ram power", 8'h5a, ram_pwr)
    `CHECK("flag set", 1'b1, s_flag)
    `CHECK("irq masked", 1'b0, s_irq)
    far.set_misc(8'ha5, 1'b0, 1'b1);
    settle(1);
    `CHECK("irq raised", 1'b1, s_irq)
    settle(3);
    far.pulse_clear();
    settle(1);
    `CHECK("irq cleared", 1'b0, s_irq)
    `CHECK("flag cleared", 1'b0, s_flag)
    // A fresh event with the interrupt already enabled
    far.set_misc(8'ha5, 1'b1, 1'b1);
    settle(5);
    `CHECK("irq on event", 1'b1, s_irq)
    end_test("supply");
    final_report();
  end
endmodule
`default_nettype wire
